// file: design/usw_pkg.sv
// package: register map, field positions and timing for the usb suspend/wake block
package usw_pkg;
  // register byte offsets on the avalon slave
  localparam logic [3:0] OFS_PORT = 4'h0;
  localparam logic [3:0] OFS_CFG = 4'h4;
  localparam logic [3:0] OFS_WAKE = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;
  // port_status_control fields
  localparam int PB_SUSPEND = 0;
  localparam int PB_RESUME = 1;
  localparam int PB_RESET = 2;
  localparam int PB_PCD = 3;
  localparam int PB_WCONN_EN = 4;
  localparam int PB_WDISC_EN = 5;
  localparam int PB_WOC_EN = 6;
  localparam int PB_RWKEN = 7;
  localparam int PB_HOST = 8;
  localparam logic [8:0] PORT_RST = 9'h000;
  // system_config_block fields
  localparam int CB_FULLSUSP = 0;
  localparam int CB_USRWAKE = 1;
  localparam logic [1:0] CFG_RST = 2'h0;
  // wake cause flags
  localparam int W_CONN = 0;
  localparam int W_DISC = 1;
  localparam int W_OC = 2;
  localparam int W_RWK = 3;
  localparam int W_USR = 4;
  localparam int W_VBUS = 5;
  localparam int W_BVAL = 6;
  localparam int W_DLINE = 7;
  localparam logic [7:0] WAKE_RST = 8'h00;
  // synchroniser lanes
  localparam int S_LCLK = 0;
  localparam int S_K = 1;
  localparam int S_DP = 2;
  localparam int S_DM = 3;
  localparam int S_CONN = 4;
  localparam int S_OC = 5;
  localparam int S_VBUS = 6;
  localparam int S_BVAL = 7;
  localparam int S_USR = 8;
  localparam int S_HWK = 9;
  localparam int S_DWK = 10;
  localparam int NSYNC = 11;
  localparam logic [10:0] SYNC_RST = 11'h700;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_TO_CYC = (2 * LINK_PERIOD_NS * CLK_MHZ) / 1000;
  localparam logic [4:0] LINK_TO = 5'(LINK_TO_CYC);
  localparam int WAKE_CYC = 4;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_LOW = 2'b01,
    ST_WAKE = 2'b10
  } usw_state_t;
endpackage

// file: design/usw_suspend_wake.sv
// usb suspend/wake controller: low-power state, transceiver suspend and wake sources
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - host suspend idles bus, blocks port, stops clock
// - host remote wake: k-state restarts clock, interrupts
// - external event clears suspend; software resumes/resets
// - disconnect-suspend connect restarts clock, interrupts
// - suspend output stops transceiver 30/60 mhz clocks
// - full-suspend control from config bit 0
// - pll may power down while suspended
// - clock-needed low lets ahb clock stop
// - phy clock disable enters, clearing leaves
// - host connect wakes with enable, or without it in suspend without phy clock disable
// - host disconnect wakes only with enable
// - host over-current wakes only with enable
// - host remote wake leaves low power
// - active-low user wake input wakes either mode
// - any vbus-valid change wakes
// - any b-session-valid change wakes
// - device data-line change wakes
// - vbus and b-valid edges unfiltered
module usw_suspend_wake (
  input wire logic i_clk, // system clock, 50 mhz
  input wire logic i_reset_n, // async reset, active low
  input wire logic [3:0] i_address, // avalon byte address
  input wire logic i_read, // avalon read
  input wire logic i_write, // avalon write
  input wire logic [31:0] i_writedata, // avalon write data
  input wire logic [3:0] i_byteenable, // avalon byte enables
  output logic [31:0] o_readdata, // avalon read data
  output logic o_waitrequest, // avalon wait request
  input wire logic i_link_clk, // transceiver clock, sampled
  input wire logic i_kstate, // bus in k-state
  input wire logic i_dp, // usb d+ level
  input wire logic i_dm, // usb d- level
  input wire logic i_connected, // device attached
  input wire logic i_overcurrent, // port over-current
  input wire logic i_vbus_valid, // vbus above 4.4 v
  input wire logic i_b_valid, // vbus above 4.0 v
  input wire logic i_user_wake_n, // user wake, active low
  input wire logic i_host_wake_n, // extra host wake, active low
  input wire logic i_dev_wake_n, // extra device wake, active low
  output logic o_phy_suspend, // transceiver suspend
  output logic o_full_suspend_ctl, // transceiver full-suspend control
  output logic o_pll_off_ok, // 480 mhz pll may power down
  output logic o_ahb_clk_needed, // system clock needed
  output logic o_port_idle, // bus idle, port traffic blocked
  output logic o_port_resume, // resume request to port
  output logic o_port_reset, // reset request to port
  output logic o_wake_irq // wake event pending
);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  usw_pkg::usw_state_t st;
  usw_pkg::usw_state_t next_st;
  logic ack;
  logic [8:0] port_q;
  logic [1:0] cfg_q;
  logic [7:0] wake_q;
  logic [7:0] ev;
  logic [7:0] wake_clr;
  logic [1:0] wcnt;
  logic [4:0] lto;
  logic link_run;
  logic [usw_pkg::NSYNC-1:0] raw;
  logic [usw_pkg::NSYNC-1:0] sa;
  logic [usw_pkg::NSYNC-1:0] s;
  logic [usw_pkg::NSYNC-1:0] p;
  logic [31:0] rd_mux;
  logic wr_go;
  logic wake_hit;
  logic lp_req;
  logic host;
  logic susp;
  logic pcd;
  logic conn_r;
  logic conn_f;
  logic oc_r;

  assign raw = {i_dev_wake_n, i_host_wake_n, i_user_wake_n, i_b_valid, i_vbus_valid,
                i_overcurrent, i_connected, i_dm, i_dp, i_kstate, i_link_clk};

  // two-stage synchroniser per pin; logic reads stage two and the delayed copy p
  genvar g;
  generate
    for (g = 0; g < usw_pkg::NSYNC; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          sa[g] <= usw_pkg::SYNC_RST[g];
          s[g] <= usw_pkg::SYNC_RST[g];
          p[g] <= usw_pkg::SYNC_RST[g];
        end else begin
          sa[g] <= raw[g];
          s[g] <= sa[g];
          p[g] <= s[g];
        end
      end
    end
  endgenerate

  // avalon handshake: one wait state on every access
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_read | i_write) & ~ack;
    end
  end
  assign o_waitrequest = (i_read | i_write) & ~ack;
  assign wr_go = i_write & ack;

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_address)
      usw_pkg::OFS_PORT: rd_mux[8:0] = port_q;
      usw_pkg::OFS_CFG: rd_mux[1:0] = cfg_q;
      usw_pkg::OFS_WAKE: rd_mux[7:0] = wake_q;
      usw_pkg::OFS_STAT: rd_mux[10:0] = {s[usw_pkg::S_OC], s[usw_pkg::S_CONN],
                                         s[usw_pkg::S_BVAL], s[usw_pkg::S_VBUS],
                                         link_run, o_pll_off_ok, o_ahb_clk_needed,
                                         o_phy_suspend, 1'b0, st};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data latched in the wait cycle so it stands when waitrequest drops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read & ~ack) begin
      o_readdata <= rd_mux;
    end
  end

  assign host = port_q[usw_pkg::PB_HOST];
  assign susp = port_q[usw_pkg::PB_SUSPEND];
  assign pcd = port_q[usw_pkg::PB_PCD];
  assign lp_req = pcd | (host & susp);

  // port control; a wake clears suspend and phy clock disable after any write
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port_q <= usw_pkg::PORT_RST;
    end else begin
      if (wr_go && i_address == usw_pkg::OFS_PORT) begin
        if (i_byteenable[0]) begin
          port_q[7:0] <= i_writedata[7:0];
        end
        if (i_byteenable[1]) begin
          port_q[8] <= i_writedata[8];
        end
      end
      if (wake_hit) begin
        port_q[usw_pkg::PB_PCD] <= 1'b0;
        port_q[usw_pkg::PB_SUSPEND] <= 1'b0;
      end
    end
  end
  assign o_port_resume = port_q[usw_pkg::PB_RESUME];
  assign o_port_reset = port_q[usw_pkg::PB_RESET];

  // system config: full-suspend control and user wake gate
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_q <= usw_pkg::CFG_RST;
    end else if (wr_go && i_address == usw_pkg::OFS_CFG && i_byteenable[0]) begin
      cfg_q <= i_writedata[1:0];
    end
  end
  assign o_full_suspend_ctl = cfg_q[usw_pkg::CB_FULLSUSP];

  a_cfg_bit0: assert property (wr_go && i_address == usw_pkg::OFS_CFG && i_byteenable[0]
    |=> o_full_suspend_ctl == $past(i_writedata[0]))
    else $error("full-suspend control does not follow config bit 0");

  // edge detectors on synchronised pins
  assign conn_r = s[usw_pkg::S_CONN] & ~p[usw_pkg::S_CONN];
  assign conn_f = ~s[usw_pkg::S_CONN] & p[usw_pkg::S_CONN];
  assign oc_r = s[usw_pkg::S_OC] & ~p[usw_pkg::S_OC];

  // qualified wake sources
  always_comb begin
    ev = 8'h00;
    ev[usw_pkg::W_CONN] = host & conn_r
      & (port_q[usw_pkg::PB_WCONN_EN] | (susp & ~pcd));
    ev[usw_pkg::W_DISC] = host & conn_f & port_q[usw_pkg::PB_WDISC_EN];
    ev[usw_pkg::W_OC] = host & oc_r & port_q[usw_pkg::PB_WOC_EN];
    ev[usw_pkg::W_RWK] = host & susp & port_q[usw_pkg::PB_RWKEN]
      & s[usw_pkg::S_K];
    ev[usw_pkg::W_USR] = (cfg_q[usw_pkg::CB_USRWAKE] & ~s[usw_pkg::S_USR])
      | (host & ~s[usw_pkg::S_HWK]) | (~host & ~s[usw_pkg::S_DWK]);
    // no filtering: every edge counts, glitches included
    ev[usw_pkg::W_VBUS] = s[usw_pkg::S_VBUS] ^ p[usw_pkg::S_VBUS];
    ev[usw_pkg::W_BVAL] = s[usw_pkg::S_BVAL] ^ p[usw_pkg::S_BVAL];
    ev[usw_pkg::W_DLINE] = ~host & ((s[usw_pkg::S_DP] ^ p[usw_pkg::S_DP])
      | (s[usw_pkg::S_DM] ^ p[usw_pkg::S_DM]));
  end
  assign wake_hit = (st == usw_pkg::ST_LOW) & (|ev);

  // wake causes: write one to clear, a new cause in the same cycle wins
  assign wake_clr = (wr_go && i_address == usw_pkg::OFS_WAKE && i_byteenable[0])
    ? i_writedata[7:0] : 8'h00;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_q <= usw_pkg::WAKE_RST;
    end else begin
      wake_q <= (wake_q & ~wake_clr) | (wake_hit ? ev : 8'h00);
    end
  end
  assign o_wake_irq = |wake_q;

  a_rwk_irq: assert property (st == usw_pkg::ST_LOW && host && susp
    && port_q[usw_pkg::PB_RWKEN] && s[usw_pkg::S_K]
    |=> o_wake_irq && wake_q[usw_pkg::W_RWK] && st == usw_pkg::ST_WAKE)
    else $error("remote wake did not flag or leave low power");

  a_conn_wake: assert property (st == usw_pkg::ST_LOW && host && conn_r
    && port_q[usw_pkg::PB_WCONN_EN] |=> st == usw_pkg::ST_WAKE ##1 !o_phy_suspend)
    else $error("enabled connect did not wake");

  a_disc_wake: assert property (st == usw_pkg::ST_LOW && host && conn_f
    && port_q[usw_pkg::PB_WDISC_EN] |=> wake_q[usw_pkg::W_DISC])
    else $error("enabled disconnect did not flag wake");

  a_oc_gate: assert property (st == usw_pkg::ST_LOW && ev == 8'h00 && lp_req
    |=> st == usw_pkg::ST_LOW)
    else $error("low power left without a qualified wake");

  a_vbus_wake: assert property (st == usw_pkg::ST_LOW
    && (s[usw_pkg::S_VBUS] != p[usw_pkg::S_VBUS])
    |=> st == usw_pkg::ST_WAKE && wake_q[usw_pkg::W_VBUS])
    else $error("vbus change did not wake");

  a_bval_wake: assert property (st == usw_pkg::ST_LOW
    && $changed(s[usw_pkg::S_BVAL]) |=> wake_q[usw_pkg::W_BVAL])
    else $error("b-valid change did not wake");

  a_dline_wake: assert property (st == usw_pkg::ST_LOW && !host
    && $changed(s[usw_pkg::S_DP]) |=> st == usw_pkg::ST_WAKE)
    else $error("data line change did not wake device");

  a_user_wake: assert property (st == usw_pkg::ST_LOW
    && cfg_q[usw_pkg::CB_USRWAKE] && !s[usw_pkg::S_USR]
    |=> !pcd && wake_q[usw_pkg::W_USR])
    else $error("user wake did not clear low power");

  // power state sequencing
  always_comb begin
    next_st = st;
    case (st)
      usw_pkg::ST_RUN: begin
        if (lp_req) begin
          next_st = usw_pkg::ST_LOW;
        end
      end
      usw_pkg::ST_LOW: begin
        if (wake_hit || !lp_req) begin
          next_st = usw_pkg::ST_WAKE;
        end
      end
      usw_pkg::ST_WAKE: begin
        if (wcnt == 2'(usw_pkg::WAKE_CYC - 1)) begin
          next_st = usw_pkg::ST_RUN;
        end
      end
      default: next_st = usw_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= usw_pkg::ST_RUN;
    end else begin
      st <= next_st;
    end
  end

  // wake hold: ST_WAKE lasts WAKE_CYC cycles while clocks settle before running again
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wcnt <= 2'h0;
    end else if (st == usw_pkg::ST_WAKE) begin
      wcnt <= wcnt + 2'h1;
    end else begin
      wcnt <= 2'h0;
    end
  end

  a_wake_hold: assert property ($rose(st == usw_pkg::ST_WAKE)
    |-> (st == usw_pkg::ST_WAKE && o_ahb_clk_needed)[*4] ##1 st == usw_pkg::ST_RUN)
    else $error("wake hold length wrong");

  a_pcd_enter: assert property (st == usw_pkg::ST_RUN && pcd
    |=> st == usw_pkg::ST_LOW ##0 o_phy_suspend)
    else $error("phy clock disable did not enter low power");

  // transceiver and clock outputs registered from the next state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_phy_suspend <= 1'b0;
      o_ahb_clk_needed <= 1'b1;
      o_pll_off_ok <= 1'b0;
    end else begin
      o_phy_suspend <= (next_st == usw_pkg::ST_LOW);
      o_ahb_clk_needed <= (next_st != usw_pkg::ST_LOW);
      // only once the transceiver clock has really stopped
      o_pll_off_ok <= (next_st == usw_pkg::ST_LOW) & ~link_run;
    end
  end

  a_clk_needed: assert property (o_phy_suspend |-> !o_ahb_clk_needed)
    else $error("clock-needed high during suspend");

  a_pll_off: assert property (o_pll_off_ok |-> o_phy_suspend && !link_run)
    else $error("pll release outside suspend");

  a_susp_out: assert property (st == usw_pkg::ST_LOW |-> o_phy_suspend)
    else $error("suspend output low in low power");

  // host suspend idles the bus and blocks the port
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_port_idle <= 1'b0;
    end else begin
      o_port_idle <= host & susp;
    end
  end

  a_host_block: assert property (host && susp && st == usw_pkg::ST_RUN
    |=> o_port_idle && o_phy_suspend)
    else $error("host suspend did not idle port");

  // transceiver clock watchdog: sampled edges within two link periods
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lto <= usw_pkg::LINK_TO;
    end else if (s[usw_pkg::S_LCLK] ^ p[usw_pkg::S_LCLK]) begin
      lto <= 5'h00;
    end else if (lto != usw_pkg::LINK_TO) begin
      lto <= lto + 5'h01;
    end
  end
  assign link_run = (lto != usw_pkg::LINK_TO);

endmodule // usw_suspend_wake
`default_nettype wire

// file: tb/usw_xcvr_model.sv
// transceiver model: link clock that stops in suspend, and the two vbus comparators
`timescale 1ns/1ps
`default_nettype none
module usw_xcvr_model #(
  parameter int VBUS_MV = 4400, // vbus-valid threshold in millivolts
  parameter int BSESS_MV = 4000 // b-session-valid threshold in millivolts
) (
  input wire logic i_suspend, // suspend request from the controller
  input wire logic [15:0] i_vbus_mv, // bus voltage seen by the comparators
  output logic o_link_clk, // transceiver clock, 160 ns period
  output logic o_vbus_valid, // vbus above the upper threshold
  output logic o_b_valid // vbus above the lower threshold
);
  // clock generation halts while suspended; odd start offset keeps it unrelated to the bus clock
  initial begin
    o_link_clk = 1'b0;
    #3.3;
    forever begin
      #80;
      if (!i_suspend) o_link_clk = ~o_link_clk;
    end
  end
  // comparators are not filtered, every crossing shows at once
  assign o_vbus_valid = (i_vbus_mv >= VBUS_MV);
  assign o_b_valid = (i_vbus_mv >= BSESS_MV);
endmodule // usw_xcvr_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the usb suspend/wake controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module tb;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [4:0] pins = 5'h01; // kstate, dp, connected, overcurrent, user wake
  logic [15:0] mv = 16'h1388; // 5000 mv
  logic [2:0] en;
  logic [31:0] v;
  logic [31:0] q;
  wire [31:0] rdata;
  wire waitreq, lclk, vbv, bv, phy_susp, full_susp, pll_ok, clk_need, idle, resume, preset, irq;
  int fail_count = 0;
  int n_tests = 0;
  always #10 i_clk = ~i_clk;
  usw_suspend_wake dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_address(addr),
    .i_read(rd), .i_write(wr), .i_writedata(wdata), .i_byteenable(4'hf), .o_readdata(rdata),
    .o_waitrequest(waitreq), .i_link_clk(lclk), .i_kstate(pins[4]), .i_dp(pins[3]),
    .i_dm(~pins[3]), .i_connected(pins[2]), .i_overcurrent(pins[1]), .i_vbus_valid(vbv),
    .i_b_valid(bv), .i_user_wake_n(pins[0]), .i_host_wake_n(1'b1), .i_dev_wake_n(1'b1),
    .o_phy_suspend(phy_susp), .o_full_suspend_ctl(full_susp), .o_pll_off_ok(pll_ok),
    .o_ahb_clk_needed(clk_need), .o_port_idle(idle), .o_port_resume(resume),
    .o_port_reset(preset), .o_wake_irq(irq));
  usw_xcvr_model model_u (.i_suspend(phy_susp), .i_vbus_mv(mv), .o_link_clk(lclk),
    .o_vbus_valid(vbv), .o_b_valid(bv));
  // one avalon transfer; request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    // waitrequest and read data are judged at the rising edge, before it updates them
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("ERROR %0t: bus timeout", $time);
    end
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // wait a bounded time for the transceiver suspend to drop
  task automatic poll(output logic woke);
    woke = 1'b0;
    for (int i = 0; i < 12 && !woke; i++) begin
      @(negedge i_clk);
      woke = (phy_susp === 1'b0);
    end
  endtask
  // enter low power, apply one pin event, judge whether it woke the core
  task automatic lp_case(input logic [8:0] port, input logic [1:0] cfg, input logic [4:0] pre,
    input logic [4:0] post, input logic [15:0] m0, input logic [15:0] m1, input int cause,
    input logic exp);
    logic [31:0] r;
    logic woke;
    @(posedge i_clk);
    pins <= pre;
    mv <= m0;
    repeat (8) @(posedge i_clk);
    bus(1'b1, usw_pkg::OFS_CFG, 32'(cfg), r);
    bus(1'b1, usw_pkg::OFS_WAKE, 32'h0000_00ff, r);
    bus(1'b1, usw_pkg::OFS_PORT, 32'(port), r);
    repeat (24) @(negedge i_clk);
    `CHK(phy_susp, 1'b1)
    `CHK(clk_need, 1'b0)
    `CHK(pll_ok, 1'b1)
    `CHK(idle, port[0] & port[8])
    bus(1'b0, usw_pkg::OFS_STAT, 32'h0000_0000, r);
    `CHK(r[6:0], 7'h29)
    @(posedge i_clk);
    pins <= post;
    mv <= m1;
    poll(woke);
    `CHK(woke, exp)
    if (woke) begin
      `CHK(clk_need, 1'b1)
      `CHK(irq, 1'b1)
      bus(1'b0, usw_pkg::OFS_WAKE, 32'h0000_0000, r);
      `CHK(r, 32'h0000_0001 << cause)
      bus(1'b0, usw_pkg::OFS_PORT, 32'h0000_0000, r);
      `CHK(r[3:0] & 4'h9, 4'h0)
    end else begin
      bus(1'b1, usw_pkg::OFS_PORT, 32'h0000_0000, r);
      poll(woke);
      `CHK(woke, 1'b1)
    end
    repeat (8) @(posedge i_clk);
  endtask
  task automatic finish_test();
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a tenth of this span
  initial begin
    #400_000;
    fail_count++;
    finish_test();
  end
  // main sequence: reset, register defaults, config bit, then every wake source
  initial begin
    void'($urandom(79955));
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    `CHK(clk_need, 1'b1)
    `CHK(phy_susp, 1'b0)
    bus(1'b0, usw_pkg::OFS_PORT, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0000)
    bus(1'b0, usw_pkg::OFS_CFG, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0000)
    bus(1'b0, 4'h2, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0000)
    repeat (4) begin
      v = $urandom;
      bus(1'b1, usw_pkg::OFS_CFG, 32'(v[1:0]), q);
      @(negedge i_clk);
      `CHK(full_susp, v[0])
      bus(1'b0, usw_pkg::OFS_CFG, 32'h0000_0000, q);
      `CHK(q, 32'(v[1:0]))
    end
    en = 3'($urandom);
    lp_case(9'h008, 2'h0, 5'h01, 5'h01, 16'h1388, 16'h1068, usw_pkg::W_VBUS, 1'b1);
    lp_case(9'h008, 2'h0, 5'h01, 5'h01, 16'h1068, 16'h0dac, usw_pkg::W_BVAL, 1'b1);
    lp_case(9'h008, 2'h0, 5'h01, 5'h09, 16'h1388, 16'h1388, usw_pkg::W_DLINE, 1'b1);
    lp_case(9'h008, 2'h2, 5'h01, 5'h00, 16'h1388, 16'h1388, usw_pkg::W_USR, 1'b1);
    lp_case(9'h108 | 9'(en[0]) << 4, 2'h0, 5'h01, 5'h05, 16'h1388, 16'h1388,
      usw_pkg::W_CONN, en[0]);
    lp_case(9'h108 | 9'(en[1]) << 5, 2'h0, 5'h05, 5'h01, 16'h1388, 16'h1388,
      usw_pkg::W_DISC, en[1]);
    lp_case(9'h108 | 9'(en[2]) << 6, 2'h0, 5'h01, 5'h03, 16'h1388, 16'h1388,
      usw_pkg::W_OC, en[2]);
    lp_case(9'h101, 2'h0, 5'h01, 5'h05, 16'h1388, 16'h1388, usw_pkg::W_CONN, 1'b1);
    lp_case(9'h181, 2'h0, 5'h01, 5'h11, 16'h1388, 16'h1388, usw_pkg::W_RWK, 1'b1);
    // after the wake software resumes, then resets the port; the resume wait is not timed
    bus(1'b1, usw_pkg::OFS_PORT, 32'h0000_0102, q);
    @(negedge i_clk);
    `CHK(resume, 1'b1)
    bus(1'b1, usw_pkg::OFS_PORT, 32'h0000_0104, q);
    @(negedge i_clk);
    `CHK(preset, 1'b1)
    `CHK(resume, 1'b0)
    bus(1'b1, usw_pkg::OFS_PORT, 32'h0000_0000, q);
    finish_test();
  end
endmodule // tb
`default_nettype wire
